// ===== src/acc_regs.svh
// register offsets, field positions, reset values and timing constants
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
`define ADDR_W 6
`define DATA_W 24
`define OFF_TIMING 6'h25
`define OFF_FLAGS 6'h26
`define OFF_CTRL 6'h27
`define TIMING_WMASK 24'h0F_FFFF
`define TIMING_RST 24'h00_0000
`define FLAGS_RST 15'h0000
`define FLD_WAKE 3:0
`define FLD_SHORT 7:4
`define FLD_LONG 11:8
`define FLD_SWWAIT 15:12
`define FLD_TD 19:16
`define BIT_VALID 23
`define BIT_ERROR 13
`define BIT_UNKNOWN 14
`define BIT_WAIT 0
`define BIT_MANUAL 1
`define BIT_IDSEL 2
`define FLD_ROUTE 19:17
`define WAIT_RST 1'b1
`define AUTO_RST 1'b1
`define IDSEL_RST 1'b1
`define ROUTE_RST 3'h0
`define LAST_BUTTON 4'hC
`define TICK_NS 1000000
`define CLK_NS 10
`define TICK_W 17
`define MS_W 16
`define ADC_W 10
`define WAKE_BASE_MS 16'h0032
`define WAKE_STEP_MS 16'h0032
`define WAKE_LAST 4'h4
`define WAKE_MAX_MS 16'h012C
`define SHORT_BASE_MS 16'h0064
`define LONG_BASE_MS 16'h012C
`define PRESS_STEP_MS 16'h0064
`define SWWAIT_BASE_MS 16'h000A
`define SWWAIT_STEP_MS 16'h0014
`define TD_BASE_MS 16'h0064
`define TD_STEP_MS 16'h0064
`define IDLE_BASE_MS 16'h03E8
`define IDLE_STEP_MS 16'h03E8
`define ROUTE_OPEN 3'h0
`define ROUTE_UART 3'h3
`endif

// ===== src/acc_pkg.sv
// types shared by the accessory timing and control logic
package acc_pkg;
`include "acc_regs.svh"

	// switch sequencing states
	typedef enum logic [1:0] {
		SW_OPEN = 2'b00,
		SW_WAIT = 2'b01,
		SW_CLOSED = 2'b10
	} sw_state_t;

	// whole state of the block
	typedef struct packed {
		logic [`TICK_W-1:0] tick_cnt;
		logic tick;
		logic [`DATA_W-1:0] timing;
		logic [14:0] flags;
		logic wait_en;
		logic auto_sw;
		logic id_report_select;
		logic [2:0] data_line_route_select;
		logic read_valid_flag;
		sw_state_t sw;
		logic [`MS_W-1:0] sw_cnt;
		logic [`MS_W-1:0] wake_cnt;
		logic [`MS_W-1:0] press_cnt;
		logic [`MS_W-1:0] td_cnt;
		logic [`MS_W-1:0] idle_cnt;
		logic vbus_seen;
		logic td_run;
		logic key_seen;
		logic short_done;
		logic long_done;
		logic adc_seen;
		logic [`ADC_W-1:0] last_adc;
		logic power_save;
		logic [`DATA_W-1:0] rdata;
		logic rvalid;
		logic sample;
		logic report;
		logic key_event;
		logic long_key_event;
		logic powered_id_start;
		logic [2:0] route;
		logic closed;
	} state_t;
endpackage

// ===== src/accessory_detect_timing_control.sv
// accessory detection timing, button flags and switch control
`timescale 1ns/1ps

module accessory_detect_timing_control
	import acc_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
)
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [`ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [`DATA_W-1:0] reg_wdata_i,
	output logic [`DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic accessory_attached_i,
	input wire logic [2:0] auto_route_i,
	input wire logic standby_i,
	input wire logic vbus_detect_i,
	input wire logic audio_tty_i,
	input wire logic switch_activity_i,
	input wire logic key_down_i,
	input wire logic [3:0] key_code_i,
	input wire logic button_error_i,
	input wire logic adc_done_i,
	input wire logic [`ADC_W-1:0] adc_result_i,
	output logic [2:0] switch_route_o,
	output logic switch_closed_o,
	output logic id_sample_o,
	output logic id_report_o,
	output logic key_event_o,
	output logic long_key_event_o,
	output logic powered_id_start_o,
	output logic power_save_o
);

	// linear time from a code, in ms
	function automatic logic [`MS_W-1:0] lin_ms(
		input logic [3:0] code,
		input logic [`MS_W-1:0] base,
		input logic [`MS_W-1:0] step
	);
		logic [`MS_W-1:0] prod;
		prod = `MS_W'(step * `MS_W'(code));
		return `MS_W'(base + prod);
	endfunction

	// saturating ms counter step
	function automatic logic [`MS_W-1:0] inc_ms(
		input logic [`MS_W-1:0] v
	);
		return (&v) ? v : `MS_W'(v + 1'b1);
	endfunction

	localparam logic [`TICK_W-1:0] TICK_LAST = `TICK_W'(TICK_CYCLES - 1);
	state_t q; // registered state
	state_t d; // next state

	// decoded times in ms
	logic [`MS_W-1:0] wake_ms;
	logic [`MS_W-1:0] short_ms;
	logic [`MS_W-1:0] long_ms;
	logic [`MS_W-1:0] swwait_ms;
	logic [`MS_W-1:0] td_ms;
	logic [`MS_W-1:0] idle_ms;

	// field decode into durations
	always_comb
	begin
		// past the last printed code stays at max
		if (q.timing[`FLD_WAKE] >= `WAKE_LAST)
			wake_ms = `WAKE_MAX_MS;
		else
			wake_ms = lin_ms(q.timing[`FLD_WAKE], `WAKE_BASE_MS, `WAKE_STEP_MS);
		short_ms = lin_ms(q.timing[`FLD_SHORT], `SHORT_BASE_MS, `PRESS_STEP_MS);
		long_ms = lin_ms(q.timing[`FLD_LONG], `LONG_BASE_MS, `PRESS_STEP_MS);
		swwait_ms = lin_ms(q.timing[`FLD_SWWAIT], `SWWAIT_BASE_MS, `SWWAIT_STEP_MS);
		td_ms = lin_ms(q.timing[`FLD_TD], `TD_BASE_MS, `TD_STEP_MS);
		idle_ms = lin_ms(q.timing[`FLD_TD], `IDLE_BASE_MS, `IDLE_STEP_MS);
	end

	// register access strobes
	logic wr_timing;
	logic wr_ctrl;
	logic rd_flags;
	logic [14:0] flag_set; // hardware flag events
	logic wait_rise; // wait bit written 0 to 1
	logic sampling; // periodic sampling active
	assign wr_timing = reg_wr_i && (reg_addr_i == `OFF_TIMING);
	assign wr_ctrl = reg_wr_i && (reg_addr_i == `OFF_CTRL);
	assign rd_flags = reg_rd_i && (reg_addr_i == `OFF_FLAGS);
	assign wait_rise = wr_ctrl && reg_wdata_i[`BIT_WAIT] && !q.wait_en;
	assign sampling = !q.id_report_select || q.power_save || standby_i;

	// next-state logic
	always_comb
	begin
		d = q;
		flag_set = '0;
		// one ms enable pulse
		d.tick = 1'b0;
		if (q.tick_cnt == TICK_LAST)
		begin
			d.tick_cnt = '0;
			d.tick = 1'b1;
		end
		else
			d.tick_cnt = `TICK_W'(q.tick_cnt + 1'b1);
		// one-cycle outputs fall by default
		d.rvalid = 1'b0;
		d.sample = 1'b0;
		d.report = 1'b0;
		d.key_event = 1'b0;
		d.long_key_event = 1'b0;
		d.powered_id_start = 1'b0;
		// register writes
		if (wr_timing)
			d.timing = (reg_wdata_i & `TIMING_WMASK) | (q.timing & ~`TIMING_WMASK);
		if (wr_ctrl)
		begin
			d.wait_en = reg_wdata_i[`BIT_WAIT];
			d.auto_sw = reg_wdata_i[`BIT_MANUAL];
			d.id_report_select = reg_wdata_i[`BIT_IDSEL];
			d.data_line_route_select = reg_wdata_i[`FLD_ROUTE];
		end
		// register reads, answered next cycle
		if (reg_rd_i)
		begin
			d.rvalid = 1'b1;
			d.rdata = '0;
			case (reg_addr_i)
				`OFF_TIMING:
				begin
					d.rdata = q.timing & `TIMING_WMASK;
					d.rdata[`BIT_VALID] = q.read_valid_flag;
				end
				`OFF_FLAGS:
					d.rdata[14:0] = q.flags;
				`OFF_CTRL:
				begin
					d.rdata[`BIT_WAIT] = q.wait_en;
					d.rdata[`BIT_MANUAL] = q.auto_sw;
					d.rdata[`BIT_IDSEL] = q.id_report_select;
					d.rdata[`FLD_ROUTE] = q.data_line_route_select;
				end
				default:
					d.rdata = '0;
			endcase
		end
		// periodic id sampling timer
		if (!sampling)
			d.wake_cnt = '0;
		else if (q.tick)
		begin
			if (inc_ms(q.wake_cnt) >= wake_ms)
			begin
				d.wake_cnt = '0;
				d.sample = 1'b1;
			end
			else
				d.wake_cnt = inc_ms(q.wake_cnt);
		end
		// conversion results, reported on change
		if (adc_done_i && !q.id_report_select)
		begin
			d.read_valid_flag = 1'b1;
			d.adc_seen = 1'b1;
			d.last_adc = adc_result_i;
			if (!q.adc_seen || adc_result_i != q.last_adc)
				d.report = 1'b1;
		end
		// key press monitor
		if (!q.id_report_select || !key_down_i)
		begin
			d.key_seen = 1'b0;
			d.short_done = 1'b0;
			d.long_done = 1'b0;
			d.press_cnt = '0;
		end
		else
		begin
			d.key_seen = 1'b1;
			if (q.tick)
				d.press_cnt = inc_ms(q.press_cnt);
			if (q.key_seen && !q.short_done && q.press_cnt >= short_ms)
			begin
				d.short_done = 1'b1;
				d.key_event = 1'b1;
				if (key_code_i <= `LAST_BUTTON)
					flag_set[key_code_i] = 1'b1;
				else
					flag_set[`BIT_UNKNOWN] = 1'b1;
			end
			if (q.key_seen && !q.long_done && q.press_cnt >= long_ms)
			begin
				d.long_done = 1'b1;
				d.long_key_event = 1'b1;
			end
		end
		if (button_error_i && q.id_report_select)
			flag_set[`BIT_ERROR] = 1'b1;
		// a read clears what it returned; a new event wins
		d.flags = (rd_flags ? 15'h0000 : q.flags) | flag_set;
		// powered accessory identification delay
		d.vbus_seen = vbus_detect_i;
		if (!vbus_detect_i)
		begin
			d.td_run = 1'b0;
			d.td_cnt = '0;
		end
		else if (!q.vbus_seen)
		begin
			d.td_run = 1'b1;
			d.td_cnt = '0;
		end
		else if (q.td_run && q.tick)
		begin
			if (inc_ms(q.td_cnt) >= td_ms)
			begin
				d.td_run = 1'b0;
				d.powered_id_start = 1'b1;
			end
			else
				d.td_cnt = inc_ms(q.td_cnt);
		end
		// inactivity timer for power save
		if (!accessory_attached_i || !audio_tty_i || switch_activity_i)
		begin
			d.idle_cnt = '0;
			d.power_save = 1'b0;
		end
		else if (q.tick && !q.power_save)
		begin
			if (inc_ms(q.idle_cnt) >= idle_ms)
				d.power_save = 1'b1;
			else
				d.idle_cnt = inc_ms(q.idle_cnt);
		end
		// switch sequencing
		case (q.sw)
			SW_OPEN:
			begin
				d.sw_cnt = '0;
				if (accessory_attached_i)
					d.sw = SW_WAIT;
			end
			SW_WAIT:
			begin
				if (!accessory_attached_i)
					d.sw = SW_OPEN;
				else if (!q.wait_en)
				begin
					// held open until software sets the bit
					if (wait_rise)
						d.sw = SW_CLOSED;
				end
				else if (q.tick)
				begin
					if (inc_ms(q.sw_cnt) >= swwait_ms)
						d.sw = SW_CLOSED;
					else
						d.sw_cnt = inc_ms(q.sw_cnt);
				end
			end
			SW_CLOSED:
			begin
				if (!accessory_attached_i)
					d.sw = SW_OPEN;
			end
			default:
				d.sw = SW_OPEN;
		endcase
		// switch positions: manual field or detected type
		d.closed = (d.sw == SW_CLOSED);
		if (!d.closed)
			d.route = `ROUTE_OPEN;
		else if (d.auto_sw)
			d.route = auto_route_i;
		else if (d.data_line_route_select > `ROUTE_UART)
			d.route = `ROUTE_OPEN;
		else
			d.route = d.data_line_route_select;
	end

	// state register with synchronous reset
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			q <= '0;
			q.timing <= `TIMING_RST;
			q.flags <= `FLAGS_RST;
			q.wait_en <= `WAIT_RST;
			q.auto_sw <= `AUTO_RST;
			q.id_report_select <= `IDSEL_RST;
			q.data_line_route_select <= `ROUTE_RST;
			q.sw <= SW_OPEN;
		end
		else
			q <= d;
	end

	// outputs straight from the state register
	assign reg_rdata_o = q.rdata;
	assign reg_rvalid_o = q.rvalid;
	assign switch_route_o = q.route;
	assign switch_closed_o = q.closed;
	assign id_sample_o = q.sample;
	assign id_report_o = q.report;
	assign key_event_o = q.key_event;
	assign long_key_event_o = q.long_key_event;
	assign powered_id_start_o = q.powered_id_start;
	assign power_save_o = q.power_save;

endmodule

// ===== verif/acc_properties.sv
// checker for the accessory timing block ports
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_props
#(
	parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
)
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [`ADDR_W-1:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [`DATA_W-1:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic accessory_attached_i,
	input wire logic vbus_detect_i,
	input wire logic audio_tty_i,
	input wire logic key_down_i,
	input wire logic switch_closed_o,
	input wire logic id_sample_o,
	input wire logic key_event_o,
	input wire logic long_key_event_o,
	input wire logic powered_id_start_o,
	input wire logic power_save_o
);
	// one clock, synchronous reset
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read unanswered");
	a_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
		else $error("stray answer");
	a_flag_upper: assert property (reg_rvalid_o && $past(reg_addr_i) == `OFF_FLAGS |-> reg_rdata_o[23:15] == 9'h000)
		else $error("flag upper bits");
	a_close_wait: assert property ($rose(accessory_attached_i) |=> !switch_closed_o [*8])
		else $error("closed early");
	a_detach_open: assert property (!accessory_attached_i [*2] |-> !switch_closed_o)
		else $error("closed detached");
	a_key_min: assert property ($rose(key_down_i) |=> !key_event_o [*8])
		else $error("key early");
	a_long_held: assert property (long_key_event_o |-> $past(key_down_i))
		else $error("long unheld");
	a_sample_gap: assert property (id_sample_o |=> !id_sample_o [*8])
		else $error("sample gap");
	a_delay_min: assert property ($rose(vbus_detect_i) |=> !powered_id_start_o [*8])
		else $error("id start early");
	a_save_cause: assert property ($rose(power_save_o) |-> $past(audio_tty_i))
		else $error("save cause");
	// main scenarios reached
	c_key: cover property (long_key_event_o);
	c_close: cover property ($rose(switch_closed_o));
	c_save: cover property ($rose(power_save_o));
endmodule
bind accessory_detect_timing_control acc_props #(.TICK_CYCLES(TICK_CYCLES)) acc_props_inst (.*);

// ===== verif/accessory_model.sv
// accessory on the id line: keys, faults, conversions
`timescale 1ns/1ps
module accessory_model
(
	input wire logic mclk_i,
	output logic key_o,
	output logic [3:0] code_o,
	output logic err_o,
	output logic done_o,
	output logic [9:0] res_o
);
	// idle levels
	initial
	begin
		key_o = 1'b0;
		code_o = 4'h0;
		err_o = 1'b0;
		done_o = 1'b0;
		res_o = 10'h000;
	end
	// hold a key, then release for a few cycles
	task press(input logic [3:0] c, input int n);
		@(negedge mclk_i);
		code_o = c;
		key_o = 1'b1;
		repeat (n) @(negedge mclk_i);
		key_o = 1'b0;
		code_o = ~c; // code not kept after release
		repeat (4) @(negedge mclk_i);
	endtask
	// one-cycle fault
	task fault();
		@(negedge mclk_i);
		err_o = 1'b1;
		@(negedge mclk_i);
		err_o = 1'b0;
	endtask
	// one conversion result
	task convert(input logic [9:0] v);
		@(negedge mclk_i);
		res_o = v;
		done_o = 1'b1;
		@(negedge mclk_i);
		done_o = 1'b0;
		res_o = ~v; // result only valid with done
	endtask
endmodule

// ===== verif/tb.sv
// self-checking bench for the accessory timing block
`timescale 1ns/1ps
`include "acc_regs.svh"
module tb;
	import acc_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [5:0] reg_addr_i = 6'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [23:0] reg_wdata_i = 24'h00_0000;
	logic [23:0] reg_rdata_o;
	logic accessory_attached_i = 1'b0;
	logic [2:0] auto_route_i = 3'h0;
	logic standby_i = 1'b0;
	logic vbus_detect_i = 1'b0;
	logic audio_tty_i = 1'b0;
	logic switch_activity_i = 1'b0;
	logic key_down_i, button_error_i, adc_done_i;
	logic [3:0] key_code_i;
	logic [9:0] adc_result_i;
	logic [2:0] switch_route_o;
	logic reg_rvalid_o, switch_closed_o, id_sample_o, id_report_o;
	logic key_event_o, long_key_event_o, powered_id_start_o, power_save_o;
	int mismatches = 0;
	int samples_checked = 0;
	// 1 ms is 10 cycles here
	always #5 mclk_i = ~mclk_i;
	accessory_detect_timing_control #(.TICK_CYCLES(10)) accessory_detect_timing_control_inst (.*);
	accessory_model accessory_model_inst (.mclk_i(mclk_i), .key_o(key_down_i), .code_o(key_code_i),
		.err_o(button_error_i), .done_o(adc_done_i), .res_o(adc_result_i));
	// verdict and end of run
	task final_report();
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// compare and count
	task chk(input string w, input logic [23:0] s, input logic [23:0] e);
		samples_checked++;
		if (s !== e)
		begin
			$display("wrong value %s exp %h seen %h", w, e, s);
			mismatches++;
		end
	endtask
	// register write, effective on return
	task wr(input logic [5:0] a, input logic [23:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge mclk_i);
		reg_wr_i = 1'b0;
		@(negedge mclk_i);
	endtask
	// register read, answer seen one cycle on
	task rd(input logic [5:0] a, input logic [23:0] e, input string w);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge mclk_i);
		reg_rd_i = 1'b0;
		chk(w, reg_rdata_o, e);
		chk("rvalid", 24'(reg_rvalid_o), 24'h00_0001);
		@(negedge mclk_i);
	endtask
	// pick an output event
	function automatic logic sel(input int w);
		case (w)
			0: return switch_closed_o;
			1: return key_event_o;
			2: return long_key_event_o;
			3: return id_sample_o;
			4: return powered_id_start_o;
			5: return power_save_o;
			default: return id_report_o;
		endcase
	endfunction
	// bounded wait, cycle count must fall in lo..hi
	task await(input int w, input int lo, input int hi, input string m);
		int n;
		n = 0;
		do
		begin
			@(negedge mclk_i);
			n++;
		end
		while (sel(w) !== 1'b1 && n <= hi);
		chk(m, 24'(n >= lo && n <= hi), 24'h00_0001);
		if (n > hi)
			final_report();
	endtask
	// reset values and access kinds
	task t_regs();
		rd(`OFF_TIMING, 24'h00_0000, "timing");
		rd(`OFF_CTRL, 24'h00_0007, "ctrl");
		rd(6'h00, 24'h00_0000, "unmapped");
		wr(`OFF_TIMING, 24'hFF_FFFF);
		rd(`OFF_TIMING, 24'h0F_FFFF, "timing ro");
		wr(`OFF_FLAGS, 24'hFF_FFFF);
		rd(`OFF_FLAGS, 24'h00_0000, "flags ro");
		wr(`OFF_CTRL, 24'hFF_FFFF);
		rd(`OFF_CTRL, 24'h0E_0007, "ctrl mask");
	endtask
	// automatic close after 30 ms wait
	task t_auto();
		wr(`OFF_TIMING, 24'h00_1000);
		wr(`OFF_CTRL, 24'h00_0007);
		auto_route_i = 3'h2;
		accessory_attached_i = 1'b1;
		await(0, 290, 305, "auto close");
		chk("auto route", 24'(switch_route_o), 24'h00_0002);
		accessory_attached_i = 1'b0;
		repeat (3) @(negedge mclk_i);
		chk("detach", 24'(switch_closed_o), 24'h00_0000);
	endtask
	// held open until commanded, then every route code
	task t_manual();
		wr(`OFF_CTRL, 24'h06_0004);
		accessory_attached_i = 1'b1;
		repeat (400) @(negedge mclk_i);
		chk("held", 24'(switch_closed_o), 24'h00_0000);
		wr(`OFF_CTRL, 24'h06_0005);
		chk("cmd close", 24'(switch_closed_o), 24'h00_0001);
		for (int c = 0; c < 8; c++)
		begin
			wr(`OFF_CTRL, 24'(c << 17) | 24'h00_0005);
			@(negedge mclk_i);
			chk("route", 24'(switch_route_o), (c < 4) ? 24'(c) : 24'h00_0000);
		end
		accessory_attached_i = 1'b0;
		wr(`OFF_CTRL, 24'h00_0007);
	endtask
	// press times and read-to-clear flags
	task t_keys();
		wr(`OFF_TIMING, 24'h00_0010);
		fork
			accessory_model_inst.press(4'h5, 3200);
			begin
				await(1, 1990, 2010, "short");
				await(2, 985, 1015, "long");
			end
		join
		rd(`OFF_FLAGS, 24'h00_0020, "flag");
		rd(`OFF_FLAGS, 24'h00_0000, "cleared");
		wr(`OFF_TIMING, 24'h00_0000);
		accessory_model_inst.press(4'hE, 1100);
		accessory_model_inst.press(4'h0, 1100);
		accessory_model_inst.press(4'hC, 1100);
		accessory_model_inst.fault();
		rd(`OFF_FLAGS, 24'h00_7001, "flags");
	endtask
	// periodic conversion and change reports
	task t_raw();
		wr(`OFF_CTRL, 24'h00_0003);
		await(3, 1, 520, "sync");
		await(3, 490, 505, "period");
		accessory_model_inst.convert(10'h155);
		repeat (8) @(negedge mclk_i);
		rd(`OFF_TIMING, 24'h80_0000, "valid");
		fork
			accessory_model_inst.convert(10'h2AA);
			await(6, 1, 6, "report");
		join
		wr(`OFF_CTRL, 24'h00_0007);
		// standby samples too; a wake code past the last saturates
		wr(`OFF_TIMING, 24'h00_0005);
		standby_i = 1'b1;
		await(3, 1, 3020, "standby");
		await(3, 2995, 3005, "wake max");
		standby_i = 1'b0;
	endtask
	// bus delay 300 ms, then power save after 1 s
	task t_timers();
		wr(`OFF_TIMING, 24'h02_0000);
		vbus_detect_i = 1'b1;
		await(4, 2990, 3010, "id delay");
		wr(`OFF_TIMING, 24'h00_0000);
		accessory_attached_i = 1'b1;
		audio_tty_i = 1'b1;
		switch_activity_i = 1'b1;
		@(negedge mclk_i);
		switch_activity_i = 1'b0;
		await(5, 9990, 10010, "save");
	endtask
	// reset in mid-run returns outputs and registers to rest
	task t_reset();
		rst_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		chk("save rst", 24'(power_save_o), 24'h00_0000);
		chk("closed rst", 24'(switch_closed_o), 24'h00_0000);
		rst_i = 1'b0;
		@(negedge mclk_i);
		rd(`OFF_TIMING, 24'h00_0000, "timing rst");
		rd(`OFF_CTRL, 24'h00_0007, "ctrl rst");
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(negedge mclk_i);
		rst_i = 1'b0;
		@(negedge mclk_i);
		t_regs();
		t_auto();
		t_manual();
		t_keys();
		t_raw();
		t_timers();
		t_reset();
		final_report();
	end
endmodule
